/* dv/light_sensor_readout_interrupt_bench.sv */
// Self-checking bench for the light sensor readout block
`timescale 1ns/100ps
module light_sensor_readout_interrupt_bench;
  localparam int STEP = 10;
  localparam int CONV = (256 - 'hb6) * STEP;
  localparam logic [6:0] ADDR = lsr_pkg::DEV_ADDR_DEFAULT;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        scl, hostSda, sdaLine, sdaOut, sdaOeN, intOeN, integrating;
  logic        intOut;
  logic [15:0] bb = 16'h0000;
  logic [15:0] ir = 16'h0000;
  int          miscompares = 0;
  int          nTests = 0;
  int          cycles = 0;

  // Open-drain data line with pull-up
  assign sdaLine = hostSda & (sdaOeN | sdaOut);
  always #2.5 clk = ~clk;

  lsr_top #(.STEP_CYCLES(STEP)) u_lsr_top (
    .clk(clk), .nrst(nrst), .scl(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .intOut(intOut), .intOeN(intOeN),
    .integrating(integrating), .broadbandSample(bb),
    .infraredSample(ir));
  lsr_host_model u_lsr_host_model (
    .clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(hostSda));

  //////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Write command byte and n data bytes, low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d,
                    input int n);
    logic [7:0] r;
    logic       a;
    u_lsr_host_model.start();
    u_lsr_host_model.xfer({ADDR, 1'b0}, 1'b1, r, a);
    chk(16'(a), 16'h0000);
    u_lsr_host_model.xfer(cmd, 1'b1, r, a);
    chk(16'(a), 16'h0000);
    for (int i = 0; i < n; i++) begin
      u_lsr_host_model.xfer(d[8*i +: 8], 1'b1, r, a);
      chk(16'(a), 16'h0000);
    end
    u_lsr_host_model.stop();
  endtask

  // Word read with optional clock stretch between the bytes
  task automatic rdw(input logic [7:0] cmd, input int gap,
                     output logic [15:0] v);
    logic a;
    wr(cmd, 16'h0000, 0);
    u_lsr_host_model.start();
    u_lsr_host_model.xfer({ADDR, 1'b1}, 1'b1, v[7:0], a);
    chk(16'(a), 16'h0000);
    u_lsr_host_model.xfer(8'hff, 1'b0, v[7:0], a);
    repeat (gap) @(posedge clk);
    u_lsr_host_model.xfer(8'hff, 1'b1, v[15:8], a);
    u_lsr_host_model.stop();
  endtask

  task automatic waitFall(input int maxc, output int n);
    n = 0;
    while (intOeN !== 1'b0 && n < maxc) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Reset state, power-up alone, timing write and read back
  task automatic t_reset();
    logic [15:0] v;
    chk(16'(integrating), 16'h0000);
    chk(16'(intOeN), 16'h0001);
    chk(16'(intOut), 16'h0000);
    rdw(8'h82, 0, v);
    chk(v, 16'h0000);
    wr(8'h80, 16'h0001, 1);
    chk(16'(integrating), 16'h0000);
    wr(8'h81, 16'h00b6, 1);
    rdw(8'h81, 0, v);
    chk(v, 16'h00b6);
  endtask

  // Conversion length, every-cycle interrupt, word reads, clear
  task automatic t_conv();
    logic [15:0] v;
    int          n;
    bb <= 16'h1234;
    ir <= 16'h0567;
    wr(8'h85, 16'hffff, 2);
    wr(8'h82, 16'h0010, 1);
    fork
      wr(8'h80, 16'h0003, 1);
      begin
        wait (integrating === 1'b1);
        waitFall(800, n);
      end
    join
    chk(16'(n > CONV - 3 && n < CONV + 3), 16'h0001);
    rdw(8'hb4, 0, v);
    chk(v, 16'h1234);
    rdw(8'hb6, 0, v);
    chk(v, 16'h0567);
    chk(16'(u_lsr_host_model.lux_band(16'h1234, v, 1'b1)), 16'd2);
    chk(16'(u_lsr_host_model.lux_band(16'h1234, v, 1'b0)), 16'd1);
    chk(16'(u_lsr_host_model.lux_band(16'h0064, 16'h0032, 1'b1)),
        16'd4);
    chk(16'(u_lsr_host_model.lux_band(16'h1800, 16'hffff, 1'b1)),
        16'd0);
    chk(16'(u_lsr_host_model.lux_band(16'h0064, 16'h0037, 1'b0)),
        16'd0);
    chk(16'(intOeN), 16'h0000);
    wr(8'h82, 16'h0000, 1);
    wr(8'he0, 16'h0000, 0);
    waitFall(2000, n);
    chk(16'(n), 16'd2000);
  endtask

  // High byte comes from the copy taken at the low byte read
  task automatic t_shadow();
    logic [15:0] v;
    bb <= 16'habcd;
    repeat (800) @(posedge clk);
    fork
      rdw(8'hb4, 1600, v);
      begin
        repeat (1700) @(posedge clk);
        bb <= 16'h5678;
      end
    join
    chk(v, 16'habcd);
  endtask

  // Threshold window, persistence runs and restart of the run
  task automatic t_persist();
    logic [15:0] v;
    int          n;
    bb <= 16'h1800;
    ir <= 16'hffff;
    wr(8'h83, 16'h1000, 2);
    wr(8'h85, 16'h2000, 2);
    wr(8'h82, 16'h0013, 1);
    rdw(8'h82, 0, v);
    chk(v, 16'h0013);
    wr(8'he0, 16'h0000, 0);
    chk(16'(intOeN), 16'h0001);
    bb <= 16'h0fff;
    waitFall(1470, n);
    chk(16'(n), 16'd1470);
    bb <= 16'h1800;
    waitFall(800, n);
    chk(16'(n), 16'd800);
    bb <= 16'h2001;
    waitFall(1470, n);
    chk(16'(n), 16'd1470);
    waitFall(900, n);
    chk(16'(n < 900), 16'h0001);
    bb <= 16'h2000;
    wr(8'h82, 16'h0011, 1);
    wr(8'he0, 16'h0000, 0);
    waitFall(1600, n);
    chk(16'(n), 16'd1600);
    bb <= 16'h0fff;
    waitFall(760, n);
    chk(16'(n < 760), 16'h0001);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    t_reset();
    t_conv();
    t_shadow();
    t_persist();
    finish_test();
  end
endmodule

/* dv/lsr_host_model.sv */
// Serial bus master model standing in for the host controller
`timescale 1ns/100ps
module lsr_host_model (
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaDrv
);
  // Bus idles released, pulled high
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // Quarter of a bit period
  task automatic q();
    repeat (10) @(posedge clk);
  endtask

  // Start or repeated start, clock left low
  task automatic start();
    sdaDrv <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sdaDrv <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask

  // Stop condition, bus left free
  task automatic stop();
    sdaDrv <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sdaDrv <= 1'b1;
    q();
  endtask

  // Eight bits MSB first plus acknowledge slot; 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic ackOut,
                      output logic [7:0] r, output logic ackIn);
    logic [8:0] sh;
    logic [8:0] rv;
    sh = {d, ackOut};
    for (int i = 8; i >= 0; i--) begin
      sdaDrv <= sh[i];
      q();
      scl <= 1'b1;
      q();
      rv[i] = sdaLine;
      q();
      scl <= 1'b0;
      q();
    end
    r = rv[8:1];
    ackIn = rv[0];
  endtask

  // Lux coefficient band from the channel ratio in hundredths; 0 = no lux
  function automatic int lux_band(input logic [15:0] c0,
                                  input logic [15:0] c1,
                                  input logic        chip);
    int r;
    r = (c0 == 16'h0000) ? 0 : (int'(c1) * 100) / int'(c0);
    if (chip) begin
      lux_band = (r <= 25) ? 1 : (r <= 38) ? 2 : (r <= 45) ? 3
                 : (r <= 60) ? 4 : 0;
    end else begin
      lux_band = (r <= 30) ? 1 : (r <= 38) ? 2 : (r <= 45) ? 3
                 : (r <= 54) ? 4 : 0;
    end
  endfunction
endmodule

/* logic/lsr_i2c_slave.sv */
// Two-wire serial bus slave moving bytes to and from the register core
`timescale 1ns/100ps
module lsr_i2c_slave
  import lsr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sdaOeN,
  lsr_if.slave      bus
);
  lsr_slave_state_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shift, next_shift;
  logic       rnw, next_rnw;
  logic       mAck, next_mAck;
  logic       first, next_first;
  logic       next_sdaOeN;
  logic       sclD;
  logic       sdaD;
  logic       sclRise, sclFall, startC, stopC;

  // Bus conditions from synchronised levels
  assign sclRise = scl & ~sclD;
  assign sclFall = ~scl & sclD;
  assign startC  = scl & sclD & sdaD & ~sda;
  assign stopC   = scl & sclD & ~sdaD & sda;
  assign bus.wrData    = shift;
  assign bus.firstByte = first;

  // Protocol sequencing
  always_comb begin
    next_st = st; next_cnt = cnt; next_shift = shift; next_rnw = rnw;
    next_mAck = mAck; next_first = first; next_sdaOeN = sdaOeN;
    bus.wrStrobe = 1'b0;
    bus.rdStrobe = 1'b0;
    if (startC) begin
      next_st = SL_ADDR; next_cnt = 4'h0; next_first = 1'b1;
      next_sdaOeN = 1'b1;
    end else if (stopC) begin
      next_st = SL_IDLE; next_sdaOeN = 1'b1;
    end else begin
      case (st)
        SL_ADDR, SL_WRITE: begin
          if (sclRise && cnt != 4'h8) begin
            next_shift = {shift[6:0], sda};
            next_cnt   = cnt + 4'h1;
          end else if (sclFall && cnt == 4'h8) begin
            if (st == SL_WRITE) begin
              bus.wrStrobe = 1'b1;
              next_sdaOeN  = 1'b0;
              next_st      = SL_ACK_W;
            end else if (shift[7:1] == DEV_ADDR) begin
              next_rnw    = shift[0];
              next_sdaOeN = 1'b0;
              next_st     = SL_ACK_A;
            end else begin
              next_st = SL_IDLE;
            end
          end
        end
        SL_ACK_A, SL_ACK_W: begin
          if (sclFall) begin
            next_cnt = 4'h0;
            if (st == SL_ACK_A && rnw) begin
              bus.rdStrobe = 1'b1;
              next_shift   = bus.rdData;
              next_sdaOeN  = bus.rdData[7];
              next_cnt     = 4'h1;
              next_st      = SL_READ;
            end else begin
              if (st == SL_ACK_W) next_first = 1'b0;
              next_sdaOeN = 1'b1;
              next_st     = SL_WRITE;
            end
          end
        end
        SL_READ: begin
          if (sclFall) begin
            if (cnt == 4'h8) begin
              next_sdaOeN = 1'b1;
              next_st     = SL_ACK_R;
            end else begin
              next_shift  = {shift[6:0], 1'b0};
              next_sdaOeN = shift[6];
              next_cnt    = cnt + 4'h1;
            end
          end
        end
        SL_ACK_R: begin
          if (sclRise) next_mAck = ~sda;
          if (sclFall) begin
            if (mAck) begin
              bus.rdStrobe = 1'b1;
              next_shift   = bus.rdData;
              next_sdaOeN  = bus.rdData[7];
              next_cnt     = 4'h1;
              next_st      = SL_READ;
            end else begin
              next_st = SL_IDLE;
            end
          end
        end
        default: next_st = SL_IDLE;
      endcase
    end
  end

  // Slave state registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st <= SL_IDLE; cnt <= 4'h0; shift <= 8'h00; rnw <= 1'b0;
      mAck <= 1'b0; first <= 1'b0; sdaOeN <= 1'b1;
      sclD <= 1'b1; sdaD <= 1'b1;
    end else begin
      st <= next_st; cnt <= next_cnt; shift <= next_shift;
      rnw <= next_rnw; mAck <= next_mAck; first <= next_first;
      sdaOeN <= next_sdaOeN; sclD <= scl; sdaD <= sda;
    end
  end
endmodule

/* logic/lsr_if.sv */
// Byte transfer link between serial slave and register core
`timescale 1ns/100ps
interface lsr_if;
  logic       wrStrobe;
  logic       firstByte;
  logic [7:0] wrData;
  logic       rdStrobe;
  logic [7:0] rdData;

  modport slave (output wrStrobe, firstByte, wrData, rdStrobe,
                 input  rdData);
  modport core  (input  wrStrobe, firstByte, wrData, rdStrobe,
                 output rdData);
endinterface

/* logic/lsr_pkg.sv */
// Constants, register map and types of the light sensor readout block
package lsr_pkg;

  // Clock and integration timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int INTEG_STEP_NS  = 2702700;
  localparam int INTEG_STEP_CYC = INTEG_STEP_NS / CLK_PERIOD_NS;
  localparam logic [8:0] STEP_TOTAL = 9'h100;

  // Register addresses
  localparam logic [4:0] ADDR_CONTROL   = 5'h00;
  localparam logic [4:0] ADDR_TIMING    = 5'h01;
  localparam logic [4:0] ADDR_INT_SETUP = 5'h02;
  localparam logic [4:0] ADDR_THR_LO_L  = 5'h03;
  localparam logic [4:0] ADDR_THR_LO_H  = 5'h04;
  localparam logic [4:0] ADDR_THR_HI_L  = 5'h05;
  localparam logic [4:0] ADDR_THR_HI_H  = 5'h06;
  localparam logic [4:0] ADDR_CH0_LO    = 5'h14;
  localparam logic [4:0] ADDR_CH0_HI    = 5'h15;
  localparam logic [4:0] ADDR_CH1_LO    = 5'h16;
  localparam logic [4:0] ADDR_CH1_HI    = 5'h17;

  // Command byte fields
  localparam int CMD_BIT      = 7;
  localparam int TYPE_MSB     = 6;
  localparam int TYPE_LSB     = 5;
  localparam int ADDR_MSB     = 4;
  localparam logic [1:0] CMD_SPECIAL  = 2'h3;
  localparam logic [4:0] SF_INT_CLEAR = 5'h00;

  // Control and interrupt setup fields
  localparam int CTRL_POWER_BIT  = 0;
  localparam int CTRL_ADC_EN_BIT = 1;
  localparam int PERSIST_MSB     = 3;
  localparam int PERSIST_LSB     = 0;
  localparam int MODE_MSB        = 5;
  localparam int MODE_LSB        = 4;
  localparam logic [3:0] PERSIST_EVERY = 4'h0;
  localparam logic [1:0] MODE_OFF      = 2'h0;
  localparam logic [3:0] RUN_MAX       = 4'hf;

  // Reset values
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  TIMING_RESET    = 8'h00;
  localparam logic [7:0]  INT_SETUP_RESET = 8'h00;
  localparam logic [15:0] THR_RESET       = 16'h0000;
  localparam logic [15:0] DATA_RESET      = 16'h0000;

  // Serial bus slave address (arbitrary value)
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  typedef enum {
    SL_IDLE, SL_ADDR, SL_ACK_A, SL_WRITE, SL_ACK_W, SL_READ, SL_ACK_R
  } lsr_slave_state_t;

endpackage

/* logic/lsr_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module lsr_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;
  logic next_dout;

  // Accept a new level once the last two stages agree
  always_comb begin
    next_dout = (s2 == s3) ? s3 : dout;
  end

  // Synchroniser chain
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1   <= INIT;
      s2   <= INIT;
      s3   <= INIT;
      dout <= INIT;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule

/* logic/lsr_top.sv */
// Light sensor readout: registers, integration timing and interrupt
//
// Overview of operation
// - Device starts powered down with no conversion until host powers it.
// - Host sets timing first, then converter enable starts both channels.
// - Command 0x80 selects control, 0x81 selects timing register.
// - Integration setting 0xb6 gives an integration cycle near 200 ms.
// - Control value 0x03 keeps power and enables converters.
// - Command 0xb4 then word read returns 0x14 then 0x15.
// - Command 0xb6 then word read returns 0x16 then 0x17.
// - Interrupt mode field 00h at address 02h disables interrupts.
// - Low and high 16-bit thresholds define the in-window range.
// - Only the broadband channel result is compared with thresholds.
// - Persistence 1 asserts on the first out-of-window conversion.
// - Persistence N asserts after N consecutive out-of-window results.
// - Interrupt pin held low until special-function clear command.
// - Persistence 0000b asserts after every conversion, thresholds ignored.
// - First written byte with top bit set is a command; its address is stored unless it is special-function.
// - Low byte read captures the high byte into a holding register.
`timescale 1ns/100ps
module lsr_top
  import lsr_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = INTEG_STEP_CYC,
  parameter logic [6:0]  DEV_ADDR    = DEV_ADDR_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOeN,
  output logic             intOut,
  output logic             intOeN,
  output logic             integrating,
  input  wire logic [15:0] broadbandSample,
  input  wire logic [15:0] infraredSample
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic rstMeta;
  logic rstN;
  logic sclSync;
  logic sdaSync;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  lsr_sync #(.INIT(1'b1)) u_sclSync (
    .clk  (clk),
    .rstN (rstN),
    .din  (scl),
    .dout (sclSync)
  );

  lsr_sync #(.INIT(1'b1)) u_sdaSync (
    .clk  (clk),
    .rstN (rstN),
    .din  (sdaIn),
    .dout (sdaSync)
  );

  lsr_if bus ();

  lsr_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
    .clk    (clk),
    .rstN   (rstN),
    .scl    (sclSync),
    .sda    (sdaSync),
    .sdaOeN (sdaOeN),
    .bus    (bus)
  );

  // Open-drain pins only ever pull low
  assign sdaOut = 1'b0;
  assign intOut = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Register file and command pointer

  logic [7:0]  control, next_control;
  logic [7:0]  timing, next_timing;
  logic [7:0]  intSetup, next_intSetup;
  logic [15:0] thrLow, next_thrLow;
  logic [15:0] thrHigh, next_thrHigh;
  logic [4:0]  ptr, next_ptr;
  logic [7:0]  shadow0, next_shadow0;
  logic [7:0]  shadow1, next_shadow1;
  logic        clearReq;
  logic [15:0] ch0Data;
  logic [15:0] ch1Data;
  logic [7:0]  rdMux;
  logic [3:0]  persist;
  logic [1:0]  intMode;
  logic        active;

  assign persist = intSetup[PERSIST_MSB:PERSIST_LSB];
  assign intMode = intSetup[MODE_MSB:MODE_LSB];
  assign active  = control[CTRL_POWER_BIT] & control[CTRL_ADC_EN_BIT];
  assign bus.rdData = rdMux;

  // Read data selected by the stored pointer
  always_comb begin
    case (ptr)
      ADDR_CONTROL:   rdMux = control;
      ADDR_TIMING:    rdMux = timing;
      ADDR_INT_SETUP: rdMux = intSetup;
      ADDR_THR_LO_L:  rdMux = thrLow[7:0];
      ADDR_THR_LO_H:  rdMux = thrLow[15:8];
      ADDR_THR_HI_L:  rdMux = thrHigh[7:0];
      ADDR_THR_HI_H:  rdMux = thrHigh[15:8];
      ADDR_CH0_LO:    rdMux = ch0Data[7:0];
      ADDR_CH0_HI:    rdMux = shadow0;
      ADDR_CH1_LO:    rdMux = ch1Data[7:0];
      ADDR_CH1_HI:    rdMux = shadow1;
      default:        rdMux = 8'h00;
    endcase
  end

  // Command decode, register writes and read side effects
  always_comb begin
    next_control = control; next_timing = timing;
    next_intSetup = intSetup; next_thrLow = thrLow;
    next_thrHigh = thrHigh; next_ptr = ptr;
    next_shadow0 = shadow0; next_shadow1 = shadow1;
    clearReq = 1'b0;
    if (bus.wrStrobe) begin
      if (bus.firstByte && bus.wrData[CMD_BIT]) begin
        if (bus.wrData[TYPE_MSB:TYPE_LSB] == CMD_SPECIAL) begin
          if (bus.wrData[ADDR_MSB:0] == SF_INT_CLEAR) clearReq = 1'b1;
        end else begin
          next_ptr = bus.wrData[ADDR_MSB:0];
        end
      end else begin
        case (ptr)
          ADDR_CONTROL:   next_control  = bus.wrData;
          ADDR_TIMING:    next_timing   = bus.wrData;
          ADDR_INT_SETUP: next_intSetup = bus.wrData;
          ADDR_THR_LO_L:  next_thrLow[7:0]   = bus.wrData;
          ADDR_THR_LO_H:  next_thrLow[15:8]  = bus.wrData;
          ADDR_THR_HI_L:  next_thrHigh[7:0]  = bus.wrData;
          ADDR_THR_HI_H:  next_thrHigh[15:8] = bus.wrData;
          default: ;
        endcase
        next_ptr = ptr + 5'h01;
      end
    end else if (bus.rdStrobe) begin
      if (ptr == ADDR_CH0_LO) next_shadow0 = ch0Data[15:8];
      if (ptr == ADDR_CH1_LO) next_shadow1 = ch1Data[15:8];
      next_ptr = ptr + 5'h01;
    end
  end

  // Register file storage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      control  <= CONTROL_RESET;
      timing   <= TIMING_RESET;
      intSetup <= INT_SETUP_RESET;
      thrLow   <= THR_RESET;
      thrHigh  <= THR_RESET;
      ptr      <= ADDR_CONTROL;
      shadow0  <= 8'h00;
      shadow1  <= 8'h00;
    end else begin
      control  <= next_control;
      timing   <= next_timing;
      intSetup <= next_intSetup;
      thrLow   <= next_thrLow;
      thrHigh  <= next_thrHigh;
      ptr      <= next_ptr;
      shadow0  <= next_shadow0;
      shadow1  <= next_shadow1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Integration timing and result capture

  logic [19:0] tick, next_tick;
  logic [8:0]  stepsLeft, next_stepsLeft;
  logic [8:0]  stepReload;
  logic [15:0] next_ch0Data;
  logic [15:0] next_ch1Data;
  logic        convDone;
  logic        next_integrating;

  assign stepReload = STEP_TOTAL - {1'b0, timing};
  assign convDone = active && tick == 20'(STEP_CYCLES - 1)
                    && stepsLeft == 9'h001;

  // Step counting; both channels captured together at the end
  always_comb begin
    next_tick = tick; next_stepsLeft = stepsLeft;
    next_ch0Data = ch0Data; next_ch1Data = ch1Data;
    next_integrating = active;
    if (!active) begin
      next_tick      = 20'h00000;
      next_stepsLeft = stepReload;
    end else if (tick == 20'(STEP_CYCLES - 1)) begin
      next_tick = 20'h00000;
      if (stepsLeft == 9'h001) begin
        next_stepsLeft = stepReload;
        next_ch0Data   = broadbandSample;
        next_ch1Data   = infraredSample;
      end else begin
        next_stepsLeft = stepsLeft - 9'h001;
      end
    end else begin
      next_tick = tick + 20'h00001;
    end
  end

  // Conversion state storage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tick        <= 20'h00000;
      stepsLeft   <= STEP_TOTAL;
      ch0Data     <= DATA_RESET;
      ch1Data     <= DATA_RESET;
      integrating <= 1'b0;
    end else begin
      tick        <= next_tick;
      stepsLeft   <= next_stepsLeft;
      ch0Data     <= next_ch0Data;
      ch1Data     <= next_ch1Data;
      integrating <= next_integrating;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Threshold, persistence and interrupt pin

  logic [3:0] runCount, next_runCount;
  logic       intFlag, next_intFlag;
  logic       next_intOeN;
  logic       outside;

  // Window test on the broadband result only
  assign outside = (broadbandSample > thrHigh)
                   || (broadbandSample < thrLow);

  // Sticky flag; a new event wins over a clear in the same cycle
  always_comb begin
    next_runCount = runCount;
    next_intFlag  = intFlag;
    if (clearReq) next_intFlag = 1'b0;
    if (convDone) begin
      if (outside) begin
        next_runCount = (runCount == RUN_MAX) ? RUN_MAX
                        : runCount + 4'h1;
      end else begin
        next_runCount = 4'h0;
      end
      if (intMode != MODE_OFF) begin
        if (persist == PERSIST_EVERY) begin
          next_intFlag = 1'b1;
        end else if (outside
                     && ({1'b0, runCount} + 5'h01) >= {1'b0, persist}) begin
          next_intFlag = 1'b1;
        end
      end
    end
    next_intOeN = ~next_intFlag;
  end

  // Interrupt state storage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      runCount <= 4'h0;
      intFlag  <= 1'b0;
      intOeN   <= 1'b1;
    end else begin
      runCount <= next_runCount;
      intFlag  <= next_intFlag;
      intOeN   <= next_intOeN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_no_conv_idle;
    @(posedge clk) disable iff (!rstN)
    !active |=> !convDone;
  endproperty
  a_no_conv_idle: assert property (p_no_conv_idle)
    else $error("conversion finished while not enabled");

  property p_step_reload;
    @(posedge clk) disable iff (!rstN)
    convDone |=> stepsLeft == STEP_TOTAL - {1'b0, $past(timing)};
  endproperty
  a_step_reload: assert property (p_step_reload)
    else $error("integration step count not reloaded from setting");

  property p_cmd_store;
    @(posedge clk) disable iff (!rstN)
    bus.wrStrobe && bus.firstByte && bus.wrData[CMD_BIT]
    && bus.wrData[TYPE_MSB:TYPE_LSB] != CMD_SPECIAL
    |=> ptr == $past(bus.wrData[ADDR_MSB:0]);
  endproperty
  a_cmd_store: assert property (p_cmd_store)
    else $error("command address not stored");

  property p_shadow_hold;
    @(posedge clk) disable iff (!rstN)
    bus.rdStrobe && ptr == ADDR_CH0_LO
    |=> shadow0 == $past(ch0Data[15:8]) && ptr == ADDR_CH0_HI;
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("high byte not captured on low byte read");

  property p_mode_off;
    @(posedge clk) disable iff (!rstN)
    intMode == MODE_OFF && !intFlag |=> !intFlag;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("interrupt raised while disabled");

  property p_every_conv;
    @(posedge clk) disable iff (!rstN)
    convDone && intMode != MODE_OFF && persist == PERSIST_EVERY
    |=> intFlag && !intOeN;
  endproperty
  a_every_conv: assert property (p_every_conv)
    else $error("no interrupt after conversion in every-cycle mode");

  property p_first_out;
    @(posedge clk) disable iff (!rstN)
    convDone && intMode != MODE_OFF && persist == 4'h1 && outside
    |=> intFlag;
  endproperty
  a_first_out: assert property (p_first_out)
    else $error("no interrupt on first out-of-window result");

  property p_run_restart;
    @(posedge clk) disable iff (!rstN)
    convDone && !outside |=> runCount == 4'h0;
  endproperty
  a_run_restart: assert property (p_run_restart)
    else $error("run count kept after in-window result");

  property p_too_short;
    @(posedge clk) disable iff (!rstN)
    convDone && !intFlag && persist != PERSIST_EVERY
    && ({1'b0, runCount} + 5'h01) < {1'b0, persist} && !clearReq
    |=> !intFlag;
  endproperty
  a_too_short: assert property (p_too_short)
    else $error("interrupt before persistence count reached");

  property p_int_hold;
    @(posedge clk) disable iff (!rstN)
    intFlag && !clearReq |=> intFlag && !intOeN;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("interrupt dropped without clear command");

endmodule
